// *** rtl/mps_link.sv ***
// Secondary-station engine for the multipoint poll/select serial link
`timescale 1ns/10ps
`default_nettype none
module mps_link
  import mps_pkg::*;
#(
  parameter int unsigned TMO_CYC = mps_pkg::MPS_TMO_CYC
) (
  input  wire logic       clk_in,        // System clock, 40 MHz
  input  wire logic       rst_in,        // Asynchronous reset, active high
  input  wire logic [6:0] group_addr_in, // Configured group address 0..99
  input  wire logic [6:0] user_addr_in,  // Configured user address 0..99
  input  wire logic       bcc_en_in,     // Block check enabled
  input  wire logic       legacy_in,     // Legacy command set enabled
  input  wire logic [7:0] rx_data_in,    // Received byte
  input  wire logic       rx_valid_in,   // Received byte strobe
  output logic      [7:0] tx_data_out,   // Byte to send
  output logic            tx_valid_out,  // Byte to send is valid
  input  wire logic       tx_ready_in,   // Transmitter takes byte
  input  wire logic [7:0] rsp_data_in,   // Pending response payload byte
  input  wire logic       rsp_valid_in,  // Response byte available
  input  wire logic       rsp_last_in,   // Last byte of this response
  output logic            rsp_ready_out, // Response byte consumed
  input  wire logic       rsp_more_in,   // Another response is queued
  output logic      [7:0] cmd_data_out,  // Accepted command byte
  output logic            cmd_valid_out, // Command byte strobe
  output logic            cmd_end_out,   // Command complete pulse
  output logic            cmd_query_out, // Completed command is a query
  output logic            cmd_param_out, // Completed command has parameters
  output logic            cmd_legacy_out, // Fast-selected block received in legacy mode
  input  wire logic       cmd_ok_in,     // Command interpreter accepts it
  output logic            cmd_flush_out, // Clear command receive buffer
  output logic            addressed_out  // Station is addressed
);
  import mps_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_HDR, S_SEL_ACK, S_SLAVE, S_RX, S_RX_BCC, S_EVAL, S_REPLY,
    S_TX_STX, S_TX_DAT, S_TX_ETX, S_TX_BCC, S_WAIT_ACK, S_TX_EOT
  } mps_st_t;

  // Digit check and two-digit decimal value
  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= MPS_CHR_0) && (c <= MPS_CHR_9);
  endfunction : is_digit

  function automatic logic [6:0] dec2(input logic [7:0] hi,
                                      input logic [7:0] lo);
    logic [7:0] h;
    logic [7:0] l;
    h = hi - MPS_CHR_0;
    l = lo - MPS_CHR_0;
    // Widen before the multiply so that tens up to 90 do not wrap
    dec2 = {3'b000, h[3:0]} * 7'h0A + {3'b000, l[3:0]};
  endfunction : dec2

  // Upper-case folding for keyword compare
  function automatic logic [7:0] upc(input logic [7:0] c);
    upc = (c >= 8'h61 && c <= 8'h7A) ? (c & ~MPS_CASE_BIT) : c;
  endfunction : upc

  mps_st_t     st_ff, nxt_st;
  logic [7:0]  hdr_ff [0:5];
  logic [2:0]  hcnt_ff;
  logic [7:0]  bcc_ff;
  logic [7:0]  cmd_ff [0:MPS_CMD_DEPTH-1];
  logic [5:0]  clen_ff;
  logic        cov_ff;
  logic        fast_ff;
  logic        query_ff;
  logic        param_ff;
  logic        bad_ff;
  logic        legacy_ff;
  logic [7:0]  reply_ff;
  logic [7:0]  tbcc_ff;
  logic [7:0]  last_ff;
  logic [31:0] tmr_ff;
  logic        tmr_on_ff;
  logic        addr_ff;
  logic [7:0]  tx_byte;
  logic [7:0]  cdat_ff;
  logic        cval_ff;
  logic        cend_ff;

  // Byte class decode
  wire is_eot    = rx_valid_in && (rx_data_in == MPS_EOT);
  wire is_stx    = rx_data_in == MPS_STX;
  wire is_etx    = rx_data_in == MPS_ETX;
  wire is_enq    = rx_data_in == MPS_ENQ;
  wire is_ack    = rx_valid_in && (rx_data_in == MPS_ACK);
  wire tmo       = tmr_on_ff && (tmr_ff >= TMO_CYC - 1);
  wire tx_fire   = tx_valid_out && tx_ready_in;

  // Header decode: digits, own address, letters
  wire hdr_dig   = is_digit(hdr_ff[0]) && is_digit(hdr_ff[1]) &&
                   is_digit(hdr_ff[2]) && is_digit(hdr_ff[3]);
  wire hdr_own   = hdr_dig &&
                   dec2(hdr_ff[0], hdr_ff[1]) == group_addr_in &&
                   dec2(hdr_ff[2], hdr_ff[3]) == user_addr_in;
  wire poll_letters   = hdr_ff[4] == MPS_CHR_P && hdr_ff[5] == MPS_CHR_O;
  wire select_letters = hdr_ff[4] == MPS_CHR_S && hdr_ff[5] == MPS_CHR_R;
  wire hdr_full  = hcnt_ff == 3'd6;

  // Keyword screening on the first command bytes, case folded
  wire [7:0] k0 = upc(cmd_ff[0]);
  wire [7:0] k1 = upc(cmd_ff[1]);
  wire [7:0] k2 = upc(cmd_ff[2]);
  wire [7:0] k3 = upc(cmd_ff[3]);
  wire kw_meas   = k0 == 8'h4D && k1 == 8'h45 && k2 == 8'h41 &&
                   k3 == 8'h53;
  wire kw_read   = k0 == 8'h52 && k1 == 8'h45 && k2 == 8'h41 &&
                   k3 == 8'h44;
  wire kw_addr   = (k0 == 8'h53 && k1 == 8'h59 && k2 == 8'h53 &&
                   k3 == 8'h54) && cov_ff;
  wire forbidden = kw_meas || kw_read || kw_addr;

  // Block check of accumulated bytes
  wire [7:0] bcc_ref = bcc_ff | MPS_BCC_SET;
  wire       rx_ok   = !bad_ff && !forbidden && cmd_ok_in;

  // Next state
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      S_IDLE, S_HDR: begin
        if (rx_valid_in && hdr_full && is_enq && poll_letters && hdr_own)
          nxt_st = rsp_valid_in ? S_TX_STX : S_TX_EOT;
        else if (rx_valid_in && hdr_full && is_enq && select_letters &&
                 hdr_own)
          nxt_st = S_SEL_ACK;
        else if (rx_valid_in && hdr_full && is_stx && select_letters &&
                 hdr_own)
          nxt_st = S_RX;
        else if (rx_valid_in && hdr_full)
          nxt_st = S_IDLE;
        else if (rx_valid_in)
          nxt_st = S_HDR;
      end
      S_SEL_ACK:  if (tx_fire) nxt_st = S_SLAVE;
      S_SLAVE:    if (rx_valid_in && is_stx) nxt_st = S_RX;
      S_RX:       if (rx_valid_in && is_etx)
                    nxt_st = bcc_en_in ? S_RX_BCC : S_EVAL;
      S_RX_BCC:   if (rx_valid_in) nxt_st = S_EVAL;
      S_EVAL:     nxt_st = S_REPLY;
      S_REPLY:    if (tx_fire) nxt_st = S_SLAVE;
      S_TX_STX:   if (tx_fire) nxt_st = S_TX_DAT;
      S_TX_DAT:   if (tx_fire && rsp_last_in) nxt_st = S_TX_ETX;
      S_TX_ETX:   if (tx_fire) nxt_st = bcc_en_in ? S_TX_BCC : S_WAIT_ACK;
      S_TX_BCC:   if (tx_fire) nxt_st = S_WAIT_ACK;
      S_WAIT_ACK: if (tmo) nxt_st = S_TX_EOT;
                  else if (is_ack)
                    nxt_st = (rsp_more_in && rsp_valid_in) ?
                             S_TX_STX : S_TX_EOT;
      S_TX_EOT:   if (tx_fire) nxt_st = S_IDLE;
      default:    nxt_st = S_IDLE;
    endcase
    // Received end-of-transmission or receive timeout drop the link
    if (is_eot && st_ff != S_TX_EOT)
      nxt_st = S_IDLE;
    if (tmo && (st_ff == S_RX || st_ff == S_RX_BCC))
      nxt_st = S_IDLE;
  end

  // State and timer for receive and acknowledge wait
  wire rx_tmr_run = (st_ff == S_RX || st_ff == S_RX_BCC);
  wire tmr_clr    = (nxt_st != st_ff) || (rx_tmr_run && rx_valid_in);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff     <= S_IDLE;
      tmr_ff    <= MPS_TMR_RST;
      tmr_on_ff <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      tmr_ff    <= tmr_clr ? MPS_TMR_RST : tmr_ff + 32'h1;
      tmr_on_ff <= (nxt_st == S_WAIT_ACK) ||
                   (nxt_st == S_RX) || (nxt_st == S_RX_BCC);
    end
  end

  // Header buffer written by index, reset at each idle-side frame
  wire hdr_take = rx_valid_in && (st_ff == S_IDLE || st_ff == S_HDR) &&
                  !is_eot;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hcnt_ff <= 3'd0;
      for (int i = 0; i < 6; i++) hdr_ff[i] <= MPS_BYTE_RST;
    end else if (hdr_take && !hdr_full) begin
      hdr_ff[hcnt_ff] <= rx_data_in;
      hcnt_ff         <= hcnt_ff + 3'd1;
    end else if (hdr_take || is_eot ||
                 (st_ff != S_IDLE && st_ff != S_HDR)) begin
      hcnt_ff <= 3'd0;
    end
  end

  // Command buffer, check sum and syntax flags
  wire rx_pay = rx_valid_in && st_ff == S_RX && !is_etx;
  wire rx_start = (nxt_st == S_RX) && (st_ff != S_RX);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      clen_ff   <= 6'h00;
      bcc_ff    <= MPS_BYTE_RST;
      cov_ff    <= 1'b0;
      query_ff  <= 1'b0;
      param_ff  <= 1'b0;
      bad_ff    <= 1'b0;
      last_ff   <= MPS_BYTE_RST;
      legacy_ff <= 1'b0;
      fast_ff   <= 1'b0;
      for (int i = 0; i < MPS_CMD_DEPTH; i++) cmd_ff[i] <= MPS_BYTE_RST;
    end else if (rx_start || is_eot) begin
      clen_ff   <= 6'h00;
      bcc_ff    <= MPS_BYTE_RST;
      cov_ff    <= 1'b0;
      param_ff  <= 1'b0;
      bad_ff    <= 1'b0;
      last_ff   <= MPS_BYTE_RST;
      // Legacy flag is taken at block start and dropped on received end-of-transmission
      legacy_ff <= rx_start && legacy_in;
      fast_ff   <= (st_ff == S_IDLE || st_ff == S_HDR);
    end else if (rx_valid_in && st_ff == S_RX) begin
      bcc_ff <= bcc_ff ^ rx_data_in;
      if (!is_etx) begin
        cmd_ff[clen_ff] <= rx_data_in;
        last_ff <= (rx_data_in == 8'h0A || rx_data_in == 8'h0D) ?
                   last_ff : rx_data_in;
        if (clen_ff == MPS_CMD_LAST) bad_ff <= 1'b1;
        else clen_ff <= clen_ff + 6'h01;
        if (rx_data_in == MPS_CHR_COL) cov_ff <= 1'b1;
        if (rx_data_in == MPS_CHR_SP)  param_ff <= 1'b1;
        if (rx_data_in < MPS_CHR_SP && rx_data_in != 8'h0A &&
            rx_data_in != 8'h0D) bad_ff <= 1'b1;
      end else begin
        query_ff <= last_ff == MPS_CHR_Q;
      end
    end else if (rx_valid_in && st_ff == S_RX_BCC) begin
      if (rx_data_in != bcc_ref) bad_ff <= 1'b1;
    end
  end

  // Reply selection, one acknowledge also covers fast addressing
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reply_ff <= MPS_ACK;
    end else if (st_ff == S_EVAL) begin
      reply_ff <= rx_ok ? MPS_ACK : MPS_NAK;
    end
  end

  // Command byte stream and completion strobe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cdat_ff <= MPS_BYTE_RST;
      cval_ff <= 1'b0;
      cend_ff <= 1'b0;
    end else begin
      cdat_ff <= rx_data_in;
      cval_ff <= rx_pay;
      // Every finished block is reported; refused ones are answered NAK
      cend_ff <= (st_ff == S_EVAL);
    end
  end

  // Transmit byte selection
  always_comb begin
    case (st_ff)
      S_SEL_ACK:  tx_byte = MPS_ACK;
      S_REPLY:    tx_byte = reply_ff;
      S_TX_STX:   tx_byte = MPS_STX;
      S_TX_DAT:   tx_byte = rsp_data_in;
      S_TX_ETX:   tx_byte = MPS_ETX;
      S_TX_BCC:   tx_byte = tbcc_ff | MPS_BCC_SET;
      default:    tx_byte = MPS_EOT;
    endcase
  end

  // A byte is offered in every sending state; payload waits for its source
  wire tx_ctl = (st_ff == S_SEL_ACK) || (st_ff == S_REPLY) ||
                (st_ff == S_TX_STX) || (st_ff == S_TX_ETX) ||
                (st_ff == S_TX_BCC) || (st_ff == S_TX_EOT);
  wire tx_pay = (st_ff == S_TX_DAT) && rsp_valid_in;

  // Transmit check sum over payload and end byte, and address status
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_ff <= 1'b0;
      tbcc_ff <= MPS_BYTE_RST;
    end else begin
      addr_ff <= (nxt_st != S_IDLE) && (nxt_st != S_HDR);
      if (st_ff == S_TX_STX && tx_fire)
        tbcc_ff <= MPS_BYTE_RST;
      else if ((st_ff == S_TX_DAT || st_ff == S_TX_ETX) && tx_fire)
        tbcc_ff <= tbcc_ff ^ tx_byte;
    end
  end

  // Byte comes straight from the selector: a register stage here would
  // add a cycle to every handshake and let data lag its strobe
  assign tx_data_out    = tx_byte;
  assign tx_valid_out   = tx_ctl || tx_pay;
  assign rsp_ready_out  = tx_pay && tx_ready_in;
  assign cmd_data_out   = cdat_ff;
  assign cmd_valid_out  = cval_ff;
  assign cmd_end_out    = cend_ff;
  assign cmd_query_out  = query_ff;
  assign cmd_param_out  = param_ff;
  assign cmd_legacy_out = legacy_ff && fast_ff;
  assign cmd_flush_out  = is_eot;
  assign addressed_out  = addr_ff;
endmodule : mps_link
`default_nettype wire

// *** rtl/mps_pkg.sv ***
// Package with characters, timing and sizes for the poll/select link engine
package mps_pkg;
  localparam logic [7:0] MPS_STX      = 8'h02;
  localparam logic [7:0] MPS_ETX      = 8'h03;
  localparam logic [7:0] MPS_EOT      = 8'h04;
  localparam logic [7:0] MPS_ENQ      = 8'h05;
  localparam logic [7:0] MPS_ACK      = 8'h06;
  localparam logic [7:0] MPS_NAK      = 8'h15;
  localparam logic [7:0] MPS_BCC_SET  = 8'h80;
  localparam logic [7:0] MPS_CHR_P    = 8'h70;
  localparam logic [7:0] MPS_CHR_O    = 8'h6F;
  localparam logic [7:0] MPS_CHR_S    = 8'h73;
  localparam logic [7:0] MPS_CHR_R    = 8'h72;
  localparam logic [7:0] MPS_CHR_0    = 8'h30;
  localparam logic [7:0] MPS_CHR_9    = 8'h39;
  localparam logic [7:0] MPS_CHR_Q    = 8'h3F;
  localparam logic [7:0] MPS_CHR_SP   = 8'h20;
  localparam logic [7:0] MPS_CHR_COL  = 8'h3A;
  localparam logic [7:0] MPS_CHR_COM  = 8'h2C;
  localparam logic [7:0] MPS_CASE_BIT = 8'h20;
  // Watchdog limit, seconds, and clock rate
  localparam int unsigned MPS_TMO_SEC = 5;
  localparam int unsigned MPS_CLK_HZ  = 40000000;
  localparam int unsigned MPS_TMO_CYC = MPS_TMO_SEC * MPS_CLK_HZ;
  // Command buffer depth and index width
  localparam int unsigned MPS_CMD_DEPTH = 64;
  localparam int unsigned MPS_CMD_AW    = 6;
  localparam logic [5:0]  MPS_CMD_LAST  = 6'h3F;
  // Reset values
  localparam logic [7:0] MPS_BYTE_RST = 8'h00;
  localparam logic [31:0] MPS_TMR_RST = 32'h0000_0000;
  typedef enum logic [1:0] {MPS_K_POLL, MPS_K_SEL, MPS_K_NONE} mps_kind_t;
endpackage : mps_pkg

// *** bench/mps_host_model.sv ***
// Host control station model for the multipoint link
`timescale 1ns/10ps
`default_nettype none
module mps_host_model (
  input  wire logic       clk_in,         // Clock
  input  wire logic       slow_in,        // Stall every other cycle
  output logic      [7:0] host_data_out,  // Byte to device
  output logic            host_valid_out, // Byte strobe
  input  wire logic [7:0] tx_data_in,     // Byte from device
  input  wire logic       tx_valid_in,    // Device byte valid
  output logic            tx_ready_out    // Host takes byte
);
  logic [7:0] got_q[$];
  // Line rests with the inverse of the last byte
  initial begin
    host_data_out  = 8'hFF;
    host_valid_out = 1'b0;
    tx_ready_out   = 1'b0;
  end
  // One byte per strobe, launched and dropped on falling edges
  task automatic send(input logic [7:0] b);
    @(negedge clk_in);
    host_data_out  = b;
    host_valid_out = 1'b1;
    @(negedge clk_in);
    host_valid_out = 1'b0;
    host_data_out  = ~b;
  endtask : send
  // Text goes out first character first
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) send(s[i]);
  endtask : send_str
  // Slow mode takes a byte only every other cycle
  always @(negedge clk_in) tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
  // Collect what the device sends for the bench to judge
  always @(posedge clk_in)
    if (tx_valid_in && tx_ready_out) got_q.push_back(tx_data_in);
endmodule : mps_host_model
`default_nettype wire

// *** bench/mps_link_assertions.sv ***
// Checker for the poll/select link engine ports
`timescale 1ns/10ps
`default_nettype none
module mps_link_chk
  import mps_pkg::*;
#(
  parameter int unsigned TMO_CYC = 100
) (
  input wire logic       clk_in,         // Clock
  input wire logic       rst_in,         // Reset
  input wire logic       legacy_in,      // Legacy mode
  input wire logic [7:0] rx_data_in,     // Host byte
  input wire logic       rx_valid_in,    // Host strobe
  input wire logic [7:0] tx_data_out,    // Sent byte
  input wire logic       tx_valid_out,   // Send valid
  input wire logic       tx_ready_in,    // Send taken
  input wire logic [7:0] cmd_data_out,   // Command byte
  input wire logic       cmd_valid_out,  // Command strobe
  input wire logic       cmd_end_out,    // Command end
  input wire logic       cmd_query_out,  // Query flag
  input wire logic       cmd_legacy_out, // Legacy flag
  input wire logic       cmd_ok_in,      // Verdict
  input wire logic       cmd_flush_out,  // Buffer clear
  input wire logic       addressed_out   // Addressed
);
  logic [15:0] wait_ff;
  logic [7:0]  last_ff;
  wire logic   eot_rx = rx_valid_in && rx_data_in == MPS_EOT;
  wire logic   etx_tx = tx_valid_out && tx_ready_in && tx_data_out == MPS_ETX;
  wire logic   run    = wait_ff != 16'h0000 && wait_ff != 16'hFFFF;
  // Cycles since a block ended with no host byte since; last text byte
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_ff <= 16'h0000;
      last_ff <= 8'h00;
    end else begin
      if (rx_valid_in) wait_ff <= 16'h0000;
      else if (etx_tx) wait_ff <= 16'h0001;
      else if (run) wait_ff <= wait_ff + 16'h0001;
      if (cmd_valid_out && cmd_data_out >= MPS_CHR_SP) last_ff <= cmd_data_out;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_tx_hold;
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("send byte changed before taken");
  property p_eot_flush; eot_rx |-> ##[0:2] cmd_flush_out; endproperty
  a_eot_flush: assert property (p_eot_flush)
    else $error("end of transmission left buffer");
  property p_eot_unaddr; eot_rx |-> ##[1:3] !addressed_out; endproperty
  a_eot_unaddr: assert property (p_eot_unaddr)
    else $error("end of transmission left station addressed");
  // Reply is offered in the same cycle as the completion strobe
  property p_ack_ok;
    cmd_end_out && cmd_ok_in |->
      ##[0:200] tx_valid_out && tx_data_out == MPS_ACK;
  endproperty
  a_ack_ok: assert property (p_ack_ok)
    else $error("accepted command not acknowledged");
  property p_nak_bad;
    cmd_end_out && !cmd_ok_in |->
      ##[0:200] tx_valid_out && tx_data_out == MPS_NAK;
  endproperty
  a_nak_bad: assert property (p_nak_bad)
    else $error("refused command not answered negative");
  property p_query;
    cmd_end_out |-> cmd_query_out == (last_ff == MPS_CHR_Q);
  endproperty
  a_query: assert property (p_query)
    else $error("query flag disagrees with last character");
  property p_legacy; cmd_legacy_out |-> legacy_in; endproperty
  a_legacy: assert property (p_legacy)
    else $error("legacy command outside legacy mode");
  property p_rsp_tmo;
    wait_ff == 16'(TMO_CYC + 40) |-> !addressed_out;
  endproperty
  a_rsp_tmo: assert property (p_rsp_tmo)
    else $error("response wait did not end");
  c_ack: cover property (cmd_end_out && cmd_ok_in);
  c_nak: cover property (cmd_end_out && !cmd_ok_in);
  c_tmo: cover property (wait_ff == 16'(TMO_CYC + 40));
endmodule : mps_link_chk
bind mps_link mps_link_chk #(.TMO_CYC(TMO_CYC)) chk_u (
  .clk_in, .rst_in, .legacy_in, .rx_data_in, .rx_valid_in, .tx_data_out,
  .tx_valid_out, .tx_ready_in, .cmd_data_out, .cmd_valid_out, .cmd_end_out,
  .cmd_query_out, .cmd_legacy_out, .cmd_ok_in, .cmd_flush_out, .addressed_out
);
`default_nettype wire

// *** bench/mps_link_test.sv ***
// Self-checking bench for the poll/select link engine
`timescale 1ns/10ps
`default_nettype none
module mps_link_test;
  import mps_pkg::*;
  localparam int unsigned TMO = 100;
  logic       clk_in, rst_in, legacy, slow, cmd_ok, addressed, cmd_param;
  logic       rx_valid, tx_valid, tx_ready, rsp_valid, rsp_last, rsp_ready;
  logic [7:0] rx_data, tx_data, rsp_data;
  logic [7:0] rsp_q[$];
  int         error_cnt, n_checks, cyc;
  mps_link #(.TMO_CYC(TMO)) dut_u (
    .clk_in, .rst_in, .group_addr_in(7'h03), .user_addr_in(7'h07),
    .bcc_en_in(1'b1), .legacy_in(legacy), .rx_data_in(rx_data),
    .rx_valid_in(rx_valid), .tx_data_out(tx_data), .tx_valid_out(tx_valid),
    .tx_ready_in(tx_ready), .rsp_data_in(rsp_data), .rsp_valid_in(rsp_valid),
    .rsp_last_in(rsp_last), .rsp_ready_out(rsp_ready), .rsp_more_in(1'b0),
    .cmd_data_out(), .cmd_valid_out(), .cmd_end_out(), .cmd_query_out(),
    .cmd_param_out(cmd_param), .cmd_legacy_out(), .cmd_ok_in(cmd_ok),
    .cmd_flush_out(), .addressed_out(addressed));
  mps_host_model host_u (
    .clk_in, .slow_in(slow), .host_data_out(rx_data),
    .host_valid_out(rx_valid), .tx_data_in(tx_data),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready));
  // Clock and hang guard
  initial begin
    clk_in = 1'b0;
    cyc    = 0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  // Pending response bytes offered in order, popped when taken
  always @(negedge clk_in) begin
    rsp_valid = rsp_q.size() > 0;
    rsp_data  = rsp_valid ? rsp_q[0] : 8'h55;
    rsp_last  = rsp_q.size() == 1;
  end
  always @(posedge clk_in) if (rsp_valid && rsp_ready) void'(rsp_q.pop_front());
  task automatic check(input string what, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Next byte from the device, waited for under a bound
  task automatic expect_tx(input logic [7:0] exp);
    int n;
    n = 0;
    while (host_u.got_q.size() == 0 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 400) check("sent byte", exp, 8'hXX);
    else check("sent byte", exp, host_u.got_q.pop_front());
  endtask : expect_tx
  task automatic quiet(input int n);
    repeat (n) @(negedge clk_in);
    check("silence", 8'h00, 8'(host_u.got_q.size()));
    check("addressed", 8'h00, {7'h00, addressed});
  endtask : quiet
  task automatic poll(input string a);
    host_u.send_str({a, "po"});
    host_u.send(MPS_ENQ);
  endtask : poll
  // Framed block with its check character
  task automatic expect_block(input string s);
    logic [7:0] x;
    x = MPS_ETX;
    expect_tx(MPS_STX);
    for (int i = 0; i < s.len(); i++) begin
      x ^= s[i];
      expect_tx(s[i]);
    end
    expect_tx(MPS_ETX);
    expect_tx(x | MPS_BCC_SET);
  endtask : expect_block
  // Fast selection of this station with one command
  task automatic select(input string cmd, input logic [7:0] exp);
    logic [7:0] x;
    x = MPS_ETX;
    for (int i = 0; i < cmd.len(); i++) x ^= cmd[i];
    host_u.send(MPS_EOT);
    host_u.send_str("0307sr");
    host_u.send(MPS_STX);
    host_u.send_str(cmd);
    host_u.send(MPS_ETX);
    host_u.send(x | MPS_BCC_SET);
    expect_tx(exp);
  endtask : select
  task automatic t_poll_empty();
    poll("0307");
    expect_tx(MPS_EOT);
    quiet(4);
    poll("0308");
    quiet(60);
    $display("test poll_empty done");
  endtask : t_poll_empty
  task automatic t_poll_data();
    slow   = 1'b1;
    rsp_q  = '{8'h41, 8'h42};
    poll("0307");
    expect_block("AB");
    host_u.send(MPS_ACK);
    expect_tx(MPS_EOT);
    quiet(4);
    slow = 1'b0;
    $display("test poll_data done");
  endtask : t_poll_data
  task automatic t_select();
    cmd_ok = 1'b1;
    select("*IDN?\n", MPS_ACK);
    check("param", 8'h00, {7'h00, cmd_param});
    cmd_ok = 1'b0;
    legacy = 1'b1;
    select("MEAS?\n", MPS_NAK);
    host_u.send(MPS_EOT);
    quiet(4);
    cmd_ok = 1'b1;
    legacy = 1'b0;
    $display("test select done");
  endtask : t_select
  task automatic t_timeouts();
    rsp_q = '{8'h5A};
    poll("0307");
    expect_block("Z");
    expect_tx(MPS_EOT);
    quiet(4);
    host_u.send(MPS_EOT);
    host_u.send_str("0307sr");
    host_u.send(MPS_STX);
    host_u.send_str("12");
    repeat (TMO + 40) @(negedge clk_in);
    host_u.send(MPS_ETX);
    host_u.send(8'hB0);
    quiet(60);
    $display("test timeouts done");
  endtask : t_timeouts
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  initial begin
    rst_in    = 1'b1;
    legacy    = 1'b0;
    slow      = 1'b0;
    cmd_ok    = 1'b1;
    error_cnt = 0;
    n_checks  = 0;
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    t_poll_empty();
    t_poll_data();
    t_select();
    t_timeouts();
    results();
  end
endmodule : mps_link_test
`default_nettype wire
